// ===== hw/memory_map_wait_state_decode.sv
// Purpose: Decode CPU reads and writes to memory areas, time wait-states, keep order.
// Assumes: CPU holds each request until its acknowledge; settings come from same-clock logic.
// Notes: One access is serviced at a time; an unmapped or illegal access ends in a fault.

// Function
// - Top eight flash words hold nonzero password
// - Boot entry words hold a branch instruction
// - Unprotected write then read to another address: read goes first
// - Protected frames keep write before read
// - Block protection programmable, active after reset
// - Frame one: writes zero, reads two waits
// - Back-to-back frame one writes add one cycle
// - Password reads always take sixteen waits
// - OTP waits programmable, one minimum
// - Flash waits programmable, zero minimum
// - Frame zero decoded on CPU memory bus
// - Frame one reached over 32-bit bus
// - Frame two 16-bit bus, writes zero, reads two
// - Program fetches from peripheral frames refused
module memory_map_wait_state_decode (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic rdValid,
  input wire logic rdProg,
  input wire logic rdWide,
  input wire logic [21:0] rdAddr,
  input wire logic wrValid,
  input wire logic wrWide,
  input wire logic [21:0] wrAddr,
  input wire logic [31:0] wrData,
  input wire logic [3:0] flashWait,
  input wire logic [3:0] otpWait,
  input wire logic canHold,
  input wire logic protectSet,
  input wire logic protectClear,
  output logic rdAck,
  output logic wrAck,
  output logic accFault,
  output logic tgtStrobe,
  output logic tgtWrite,
  output logic tgtWide,
  output logic [21:0] tgtAddr,
  output logic [31:0] tgtData,
  output mmap_pkg::region_e tgtRegion,
  output logic [1:0] flashSector,
  output logic flashReserved,
  output logic bootEntryHit,
  output logic protActive
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } state_e;

  // ==========================================================================
  // Sequencer
  state_e state, next_state;
  logic next_rdAck, next_wrAck, next_accFault, next_tgtStrobe, next_tgtWrite, next_tgtWide;
  logic [21:0] next_tgtAddr;
  logic [31:0] next_tgtData;
  mmap_pkg::region_e next_tgtRegion;
  logic [1:0] next_flashSector;
  logic next_flashReserved, next_bootEntryHit, next_protActive;
  logic curCan, next_curCan, lastPf1Wr, next_lastPf1Wr, pf1Gap, next_pf1Gap;
  mmap_pkg::region_e rdReg, wrReg, curReg;
  logic wrFirst, pickWr, pickRd, gapBlock, load, expired;
  logic [21:0] curAddr, flashOffset;
  logic [4:0] loadValue;

  wait_state_counter #(.W(mmap_pkg::WS_W)) u_waits (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .load(load),
    .loadValue(loadValue),
    .expired(expired)
  );

  always_comb begin
    rdReg = mmap_pkg::decode(rdAddr, rdProg);
    wrReg = mmap_pkg::decode(wrAddr, 1'b0);
    // Unprotected pairs keep pipeline order; protected or same-address pairs keep program order.
    wrFirst = !rdValid || (rdAddr == wrAddr) ||
              (protActive && (mmap_pkg::isProt(rdReg) || mmap_pkg::isProt(wrReg)));
    pickWr = wrValid && wrFirst;
    pickRd = rdValid && !pickWr;
    gapBlock = pickWr && pf1Gap && (wrReg == mmap_pkg::REG_PF1);
    curReg = pickWr ? wrReg : rdReg;
    curAddr = pickWr ? wrAddr : rdAddr;
    flashOffset = curAddr - mmap_pkg::FLASH_LO;
    loadValue = mmap_pkg::waitsFor(curReg, pickWr, curAddr,
                                   flashWait, otpWait);
    load = 1'b0;
    next_state = state;
    next_rdAck = 1'b0;
    next_wrAck = 1'b0;
    next_accFault = accFault;
    next_tgtStrobe = 1'b0;
    next_tgtWrite = tgtWrite;
    next_tgtWide = tgtWide;
    next_tgtAddr = tgtAddr;
    next_tgtData = tgtData;
    next_tgtRegion = tgtRegion;
    next_flashSector = flashSector;
    next_flashReserved = flashReserved;
    next_bootEntryHit = bootEntryHit;
    next_curCan = curCan;
    next_lastPf1Wr = lastPf1Wr;
    next_pf1Gap = 1'b0;
    next_protActive = protectSet ? 1'b1 : (protectClear ? 1'b0 : protActive);
    case (state)
      ST_IDLE: begin
        if ((pickWr || pickRd) && !gapBlock) begin
          next_tgtWrite = pickWr;
          next_tgtRegion = curReg;
          if (curReg == mmap_pkg::REG_NONE) begin
            next_accFault = 1'b1;
            next_rdAck = pickRd;
            next_wrAck = pickWr;
            next_state = ST_DONE;
          end else begin
            load = 1'b1;
            next_accFault = 1'b0;
            next_tgtStrobe = 1'b1;
            next_tgtAddr = curAddr;
            next_tgtData = wrData;
            // Every region except frame two carries a full 32-bit word in one beat.
            next_tgtWide = (pickWr ? wrWide : rdWide) && (curReg != mmap_pkg::REG_PF2);
            next_flashSector = flashOffset[mmap_pkg::SECTOR_SHIFT +: 2];
            next_flashReserved = (curReg == mmap_pkg::REG_FLASH) &&
                                 (curAddr >= mmap_pkg::SEC_RES_LO);
            next_bootEntryHit = pickRd && (curAddr >= mmap_pkg::BOOT_ENTRY_LO) &&
                                (curAddr <= mmap_pkg::BOOT_ENTRY_HI);
            next_curCan = (curReg == mmap_pkg::REG_PF1) && (curAddr <= mmap_pkg::CAN_HI);
            next_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (expired && !(canHold && curCan)) begin
          next_rdAck = !tgtWrite;
          next_wrAck = tgtWrite;
          next_lastPf1Wr = tgtWrite && (tgtRegion == mmap_pkg::REG_PF1);
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_pf1Gap = lastPf1Wr;
        next_lastPf1Wr = 1'b0;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      rdAck <= 1'b0;
      wrAck <= 1'b0;
      accFault <= 1'b0;
      tgtStrobe <= 1'b0;
      tgtWrite <= 1'b0;
      tgtWide <= 1'b0;
      tgtAddr <= '0;
      tgtData <= '0;
      tgtRegion <= mmap_pkg::REG_NONE;
      flashSector <= 2'h0;
      flashReserved <= 1'b0;
      bootEntryHit <= 1'b0;
      protActive <= mmap_pkg::PROT_RESET;
      curCan <= 1'b0;
      lastPf1Wr <= 1'b0;
      pf1Gap <= 1'b0;
    end else begin
      state <= next_state;
      rdAck <= next_rdAck;
      wrAck <= next_wrAck;
      accFault <= next_accFault;
      tgtStrobe <= next_tgtStrobe;
      tgtWrite <= next_tgtWrite;
      tgtWide <= next_tgtWide;
      tgtAddr <= next_tgtAddr;
      tgtData <= next_tgtData;
      tgtRegion <= next_tgtRegion;
      flashSector <= next_flashSector;
      flashReserved <= next_flashReserved;
      bootEntryHit <= next_bootEntryHit;
      protActive <= next_protActive;
      curCan <= next_curCan;
      lastPf1Wr <= next_lastPf1Wr;
      pf1Gap <= next_pf1Gap;
    end
  end

  // ==========================================================================
  // Checks
  logic rdIssue, wrIssue;
  assign rdIssue = tgtStrobe && !tgtWrite;
  assign wrIssue = tgtStrobe && tgtWrite;

  sequence s_noAck2;
    !rdAck [*2];
  endsequence
  sequence s_pfReadDone;
    s_noAck2 ##1 rdAck;
  endsequence

  property p_pf_read;
    @(posedge ref_clk) disable iff (sys_rst)
      rdIssue && (tgtRegion == mmap_pkg::REG_PF2) |-> ##1 s_pfReadDone;
  endproperty
  a_pf_read: assert property (p_pf_read) else $error("frame read not two waits");

  property p_pf1_read;
    @(posedge ref_clk) disable iff (sys_rst)
      rdIssue && (tgtRegion == mmap_pkg::REG_PF1) && !curCan |-> ##1 s_pfReadDone;
  endproperty
  a_pf1_read: assert property (p_pf1_read) else $error("frame one read not two waits");

  property p_pf_write;
    @(posedge ref_clk) disable iff (sys_rst)
      wrIssue && (tgtRegion == mmap_pkg::REG_PF2) |-> ##1 wrAck;
  endproperty
  a_pf_write: assert property (p_pf_write) else $error("frame write not zero waits");

  property p_pwd;
    @(posedge ref_clk) disable iff (sys_rst)
      rdIssue && (tgtRegion == mmap_pkg::REG_FLASH) && (tgtAddr >= mmap_pkg::PWD_LO)
      |-> ##1 !rdAck [*8] ##1 !rdAck [*8] ##1 rdAck;
  endproperty
  a_pwd: assert property (p_pwd) else $error("password read not sixteen waits");

  property p_ram;
    @(posedge ref_clk) disable iff (sys_rst)
      tgtStrobe && (tgtRegion inside {mmap_pkg::REG_RAM, mmap_pkg::REG_PF0})
      |-> ##1 (rdAck || wrAck);
  endproperty
  a_ram: assert property (p_ram) else $error("ram access not zero waits");

  property p_otp;
    @(posedge ref_clk) disable iff (sys_rst)
      rdIssue && (tgtRegion == mmap_pkg::REG_OTP) |-> ##1 !rdAck;
  endproperty
  a_otp: assert property (p_otp) else $error("otp read below one wait");

  property p_prog_fault;
    @(posedge ref_clk) disable iff (sys_rst)
      (state == ST_IDLE) && rdValid && rdProg && !wrValid && (rdAddr >= mmap_pkg::PF1_LO) &&
      (rdAddr <= mmap_pkg::PF2_HI) |=> rdAck && accFault && !tgtStrobe;
  endproperty
  a_prog_fault: assert property (p_prog_fault) else $error("frame fetch serviced");

  property p_prot_order;
    @(posedge ref_clk) disable iff (sys_rst)
      (state == ST_IDLE) && rdValid && wrValid && protActive && !pf1Gap &&
      (wrReg != mmap_pkg::REG_NONE) &&
      (rdReg inside {mmap_pkg::REG_PF1, mmap_pkg::REG_PF2}) |=> wrIssue;
  endproperty
  a_prot_order: assert property (p_prot_order) else $error("protected read overtook write");

  property p_pipe_order;
    @(posedge ref_clk) disable iff (sys_rst)
      (state == ST_IDLE) && rdValid && wrValid && (rdAddr != wrAddr) &&
      (rdReg != mmap_pkg::REG_NONE) && (!protActive ||
      ((rdReg == mmap_pkg::REG_RAM) && (wrReg == mmap_pkg::REG_RAM))) |=> rdIssue;
  endproperty
  a_pipe_order: assert property (p_pipe_order) else $error("unprotected write went first");

  property p_prot_reset;
    @(posedge ref_clk) sys_rst |=> protActive;
  endproperty
  a_prot_reset: assert property (p_prot_reset) else $error("protection off after reset");

  property p_pf1_gap;
    @(posedge ref_clk) disable iff (sys_rst)
      wrAck && (tgtRegion == mmap_pkg::REG_PF1) && !accFault
      |-> ##2 !(wrIssue && (tgtRegion == mmap_pkg::REG_PF1));
  endproperty
  a_pf1_gap: assert property (p_pf1_gap) else $error("frame one writes not spaced");

endmodule // memory_map_wait_state_decode

// ===== hw/mmap_pkg.sv
// Purpose: Shared constants and types for the memory map decoder.
// Assumes: 22-bit word addresses, 16-bit words, one system clock.
// Notes: Region bounds outside the flash and peripheral frames are plain defaults.
package mmap_pkg;

  // ==========================================================================
  // Address map
  localparam int ADDR_W = 22;
  localparam int WS_W = 5;
  localparam logic [21:0] RAM_M_HI = 22'h0007ff;
  localparam logic [21:0] PF0_LO = 22'h000800;
  localparam logic [21:0] PF0_HI = 22'h000fff;
  localparam logic [21:0] PF1_LO = 22'h006000;
  localparam logic [21:0] PF1_HI = 22'h006fff;
  localparam logic [21:0] CAN_HI = 22'h0063ff;
  localparam logic [21:0] PF2_LO = 22'h007000;
  localparam logic [21:0] PF2_HI = 22'h007fff;
  localparam logic [21:0] RAML_LO = 22'h008000;
  localparam logic [21:0] RAML_HI = 22'h009fff;
  localparam logic [21:0] OTP_LO = 22'h3d7800;
  localparam logic [21:0] OTP_HI = 22'h3d7bff;
  localparam logic [21:0] FLASH_LO = 22'h3e8000;
  localparam logic [21:0] FLASH_HI = 22'h3f7fff;
  localparam logic [21:0] SEC_RES_LO = 22'h3f7f80;
  localparam logic [21:0] BOOT_ENTRY_LO = 22'h3f7ff6;
  localparam logic [21:0] BOOT_ENTRY_HI = 22'h3f7ff7;
  localparam logic [21:0] PWD_LO = 22'h3f7ff8;
  localparam logic [21:0] RAMH_LO = 22'h3f8000;
  localparam logic [21:0] RAMH_HI = 22'h3f9fff;
  localparam logic [21:0] BOOT_LO = 22'h3ff000;
  localparam int SECTOR_SHIFT = 14;

  // ==========================================================================
  // Wait-state counts and protection reset state
  localparam logic [4:0] WS_RAM = 5'h00;
  localparam logic [4:0] WS_PF_WR = 5'h00;
  localparam logic [4:0] WS_PF_RD = 5'h02;
  localparam logic [4:0] WS_OTP_MIN = 5'h01;
  localparam logic [4:0] WS_BOOT = 5'h01;
  localparam logic [4:0] WS_PWD = 5'h10;
  localparam logic PROT_RESET = 1'b1;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_RAM = 3'b001,
    REG_PF0 = 3'b010,
    REG_PF1 = 3'b011,
    REG_PF2 = 3'b100,
    REG_OTP = 3'b101,
    REG_FLASH = 3'b110,
    REG_BOOT = 3'b111
  } region_e;

  // ==========================================================================
  // Decode helpers
  function automatic region_e decode(input logic [21:0] a, input logic prog);
    region_e r;
    r = REG_NONE;
    if (a <= RAM_M_HI) begin
      r = REG_RAM;
    end else if (a >= PF0_LO && a <= PF0_HI) begin
      r = prog ? REG_NONE : REG_PF0;
    end else if (a >= PF1_LO && a <= PF1_HI) begin
      r = prog ? REG_NONE : REG_PF1;
    end else if (a >= PF2_LO && a <= PF2_HI) begin
      r = prog ? REG_NONE : REG_PF2;
    end else if (a >= RAML_LO && a <= RAML_HI) begin
      r = REG_RAM;
    end else if (a >= OTP_LO && a <= OTP_HI) begin
      r = REG_OTP;
    end else if (a >= FLASH_LO && a <= FLASH_HI) begin
      r = REG_FLASH;
    end else if (a >= RAMH_LO && a <= RAMH_HI) begin
      r = REG_RAM;
    end else if (a >= BOOT_LO) begin
      r = REG_BOOT;
    end
    return r;
  endfunction

  function automatic logic [4:0] waitsFor(input region_e r, input logic w, input logic [21:0] a,
                                          input logic [3:0] fw, input logic [3:0] ow);
    logic [4:0] n;
    n = WS_RAM;
    case (r)
      REG_PF1, REG_PF2: begin
        n = w ? WS_PF_WR : WS_PF_RD;
      end
      REG_OTP: begin
        n = ({1'b0, ow} < WS_OTP_MIN) ? WS_OTP_MIN : {1'b0, ow};
      end
      REG_FLASH: begin
        // Reads of the password words stay slow so a key search cannot be sped up.
        n = (!w && a >= PWD_LO) ? WS_PWD : {1'b0, fw};
      end
      REG_BOOT: begin
        n = WS_BOOT;
      end
      default: begin
        n = WS_RAM;
      end
    endcase
    return n;
  endfunction

  function automatic logic isProt(input region_e r);
    return (r == REG_PF1) || (r == REG_PF2);
  endfunction

endpackage

// ===== hw/wait_state_counter.sv
// Purpose: Down-counter that times the wait-states of one access.
// Assumes: Load and count on the system clock.
// Notes: Expired is high whenever the count stands at zero.
module wait_state_counter #(
  parameter int W = 5
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  output logic expired
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = loadValue;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign expired = (count == '0);

endmodule // wait_state_counter

// ===== verification/cpu_model.sv
// Purpose: CPU core model that issues program and data requests to the decoder.
// Assumes: Requests change just after a rising edge and hold until acknowledged.
// Notes: Released address lines carry the inverse of their last value.
module cpu_model #(
  parameter bit SECURED = 1'b0,
  parameter bit ROM_PART = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rdAck,
  input wire logic wrAck,
  input wire logic accFault,
  output logic rdValid,
  output logic rdProg,
  output logic rdWide,
  output logic [21:0] rdAddr,
  output logic wrValid,
  output logic wrWide,
  output logic [21:0] wrAddr,
  output logic [31:0] wrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held;

  initial begin
    held = 1'b0;
    rdValid = 1'b0;
    rdProg = 1'b0;
    rdWide = 1'b0;
    rdAddr = 22'h000000;
    wrValid = 1'b0;
    wrWide = 1'b0;
    wrAddr = 22'h000000;
    wrData = 32'h00000000;
  end

  // ==========================================================================
  // Transfers
  // A kept request is replaced at its acknowledge edge, so two accesses run back to back.
  task automatic access(input logic wr, input logic [21:0] a, input logic prog,
      input logic wide, input logic keep, output int lat, output logic flt);
    logic p;
    p = prog;
    // Code never runs from the reserved security words, so such fetches go out as data.
    if (a >= 22'h3f7ff0 && a <= 22'h3f7ff5) begin
      p = 1'b0;
    end
    lat = 0;
    flt = 1'b0;
    // Software keeps out of the filled words once secured, and ROM parts out of reserved words.
    if ((SECURED && a >= mmap_pkg::SEC_RES_LO && a <= 22'h3f7ff5) ||
        (ROM_PART && a >= 22'h3f7ff0 && a <= 22'h3f7ff5) ||
        (ROM_PART && a >= 22'h3d7bfc && a <= 22'h3d7bff)) begin
      return;
    end
    if (!held) begin
      @(posedge ref_clk);
    end
    if (wr) begin
      wrValid <= 1'b1;
      wrWide <= wide;
      wrAddr <= a;
      wrData <= {10'h000, a};
    end else begin
      rdValid <= 1'b1;
      rdProg <= p;
      rdWide <= wide;
      rdAddr <= a;
    end
    do begin
      @(posedge ref_clk);
      lat++;
    end while ((wr ? wrAck : rdAck) !== 1'b1 && lat < 100);
    flt = accFault;
    held = keep;
    if (!keep && wr) begin
      wrValid <= 1'b0;
      wrAddr <= ~a;
      wrData <= ~wrData;
    end else if (!keep) begin
      rdValid <= 1'b0;
      rdAddr <= ~a;
    end
  endtask

  // Write and read raised together, each dropped at its own acknowledge edge.
  task automatic both(input logic [21:0] wa, input logic [21:0] ra);
    logic wp;
    logic rp;
    int n;
    wp = 1'b1;
    rp = 1'b1;
    n = 0;
    @(posedge ref_clk);
    wrValid <= 1'b1;
    wrWide <= 1'b0;
    wrAddr <= wa;
    rdValid <= 1'b1;
    rdProg <= 1'b0;
    rdWide <= 1'b0;
    rdAddr <= ra;
    while ((wp || rp) && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (wp && wrAck === 1'b1) begin
        wp = 1'b0;
        wrValid <= 1'b0;
        wrAddr <= ~wa;
      end
      if (rp && rdAck === 1'b1) begin
        rp = 1'b0;
        rdValid <= 1'b0;
        rdAddr <= ~ra;
      end
    end
  endtask
endmodule // cpu_model

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the memory map decoder.
// Assumes: Latency counts edges from raising a request to seeing its acknowledge.
// Notes: An idle access completes N waits after N plus three edges.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, sys_rst, canHold, protectSet, protectClear;
  logic rdValid, rdProg, rdWide, wrValid, wrWide, rdAck, wrAck, accFault;
  logic tgtStrobe, tgtWrite, tgtWide, flashReserved, bootEntryHit, protActive;
  logic [21:0] rdAddr, wrAddr, tgtAddr;
  logic [31:0] wrData, tgtData;
  logic [3:0] flashWait, otpWait;
  logic [1:0] flashSector;
  mmap_pkg::region_e tgtRegion;
  int err_total, n_compared, nStrobe, lat;
  logic flt;
  logic orderQ[$];

  memory_map_wait_state_decode dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .rdValid(rdValid),
    .rdProg(rdProg), .rdWide(rdWide), .rdAddr(rdAddr), .wrValid(wrValid), .wrWide(wrWide),
    .wrAddr(wrAddr), .wrData(wrData), .flashWait(flashWait), .otpWait(otpWait),
    .canHold(canHold), .protectSet(protectSet), .protectClear(protectClear), .rdAck(rdAck),
    .wrAck(wrAck), .accFault(accFault), .tgtStrobe(tgtStrobe), .tgtWrite(tgtWrite),
    .tgtWide(tgtWide), .tgtAddr(tgtAddr), .tgtData(tgtData), .tgtRegion(tgtRegion),
    .flashSector(flashSector), .flashReserved(flashReserved), .bootEntryHit(bootEntryHit),
    .protActive(protActive));

  cpu_model cpuU (.ref_clk(ref_clk), .rdAck(rdAck), .wrAck(wrAck), .accFault(accFault),
    .rdValid(rdValid), .rdProg(rdProg), .rdWide(rdWide), .rdAddr(rdAddr), .wrValid(wrValid),
    .wrWide(wrWide), .wrAddr(wrAddr), .wrData(wrData));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Strobe order tells which of two pending requests went out first.
  always @(posedge ref_clk) begin
    if (tgtStrobe === 1'b1) begin
      nStrobe++;
      orderQ.push_back(tgtWrite);
    end
  end

  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [21:0] a, input int n,
      input mmap_pkg::region_e r, input logic keep = 1'b0);
    cpuU.access(wr, a, 1'b0, 1'b1, keep, lat, flt);
    check(lat, n + 3);
    check(flt, 1'b0);
    check(tgtRegion, r);
    check(tgtAddr, a);
    check(tgtWrite, wr);
    if (wr) begin
      check(tgtData, {10'h000, a});
    end
  endtask

  task automatic fault(input logic [21:0] a, input logic prog);
    int s;
    s = nStrobe;
    cpuU.access(1'b0, a, prog, 1'b0, 1'b0, lat, flt);
    check(lat, 2);
    check(flt, 1'b1);
    check(nStrobe, s);
  endtask

  task automatic pulse(input logic on);
    @(posedge ref_clk);
    if (on) protectSet <= 1'b1;
    else protectClear <= 1'b1;
    @(posedge ref_clk);
    protectSet <= 1'b0;
    protectClear <= 1'b0;
    @(posedge ref_clk);
    check(protActive, on);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_waits;
    acc(1'b0, 22'h000100, 0, mmap_pkg::REG_RAM);
    acc(1'b1, 22'h0007ff, 0, mmap_pkg::REG_RAM);
    acc(1'b0, 22'h000900, 0, mmap_pkg::REG_PF0);
    acc(1'b0, 22'h008000, 0, mmap_pkg::REG_RAM);
    acc(1'b0, 22'h3f8000, 0, mmap_pkg::REG_RAM);
    acc(1'b0, 22'h3ff000, 1, mmap_pkg::REG_BOOT);
    acc(1'b0, 22'h006800, 2, mmap_pkg::REG_PF1);
    check(tgtWide, 1'b1);
    acc(1'b1, 22'h006800, 0, mmap_pkg::REG_PF1);
    acc(1'b0, 22'h007000, 2, mmap_pkg::REG_PF2);
    check(tgtWide, 1'b0);
    acc(1'b1, 22'h007ffe, 0, mmap_pkg::REG_PF2);
    otpWait <= 4'h0;
    acc(1'b0, 22'h3d7800, 1, mmap_pkg::REG_OTP);
    otpWait <= 4'h4;
    acc(1'b0, 22'h3d7bff, 4, mmap_pkg::REG_OTP);
    $display("wait-state test done");
  endtask

  task automatic t_gap;
    acc(1'b1, 22'h006800, 0, mmap_pkg::REG_PF1, 1'b1);
    acc(1'b1, 22'h006802, 1, mmap_pkg::REG_PF1);
    acc(1'b1, 22'h000010, 0, mmap_pkg::REG_RAM, 1'b1);
    acc(1'b1, 22'h000012, 0, mmap_pkg::REG_RAM);
    $display("back-to-back write test done");
  endtask

  task automatic t_fault;
    fault(22'h000900, 1'b1);
    fault(22'h006000, 1'b1);
    fault(22'h007fff, 1'b1);
    fault(22'h001000, 1'b0);
    cpuU.access(1'b0, 22'h000100, 1'b1, 1'b0, 1'b0, lat, flt);
    check(flt, 1'b0);
    $display("refusal test done");
  endtask

  task automatic t_can;
    canHold <= 1'b1;
    acc(1'b0, 22'h006800, 2, mmap_pkg::REG_PF1);
    fork
      begin
        repeat (6) @(posedge ref_clk);
        canHold <= 1'b0;
      end
    join_none
    cpuU.access(1'b0, 22'h006000, 1'b0, 1'b0, 1'b0, lat, flt);
    check(lat > 5, 1'b1);
    acc(1'b0, 22'h0063ff, 2, mmap_pkg::REG_PF1);
    $display("stretch test done");
  endtask

  task automatic t_order;
    check(protActive, 1'b1);
    orderQ.delete();
    cpuU.both(22'h006800, 22'h006804);
    check(orderQ[0], 1'b1);
    pulse(1'b0);
    orderQ.delete();
    cpuU.both(22'h007010, 22'h007020);
    check(orderQ[0], 1'b0);
    pulse(1'b1);
    orderQ.delete();
    cpuU.both(22'h000100, 22'h000200);
    check(orderQ[0], 1'b0);
    $display("ordering test done");
  endtask

  task automatic t_flash;
    flashWait <= 4'h3;
    acc(1'b0, 22'h3e8000, 3, mmap_pkg::REG_FLASH);
    check(flashSector, 2'h0);
    acc(1'b0, 22'h3f4000, 3, mmap_pkg::REG_FLASH);
    check({flashReserved, flashSector}, 3'h3);
    acc(1'b0, 22'h3f7f80, 3, mmap_pkg::REG_FLASH);
    check(flashReserved, 1'b1);
    acc(1'b0, 22'h3f7ff6, 3, mmap_pkg::REG_FLASH);
    check(bootEntryHit, 1'b1);
    acc(1'b0, 22'h3f7ff8, 16, mmap_pkg::REG_FLASH);
    flashWait <= 4'h0;
    acc(1'b0, 22'h3ec000, 0, mmap_pkg::REG_FLASH);
    check(flashSector, 2'h1);
    $display("flash test done");
  endtask

  // ==========================================================================
  // Run control
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end

  initial begin
    sys_rst = 1'b1;
    canHold = 1'b0;
    protectSet = 1'b0;
    protectClear = 1'b0;
    flashWait = 4'h0;
    otpWait = 4'h1;
    err_total = 0;
    n_compared = 0;
    nStrobe = 0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    check(tgtRegion, mmap_pkg::REG_NONE);
    t_order();
    t_waits();
    t_gap();
    t_fault();
    t_can();
    t_flash();
    end_sim;
  end
endmodule // tb_top
